/* inc/ttle_pkg.sv */
// Constants and types for the type-test, trap and load execution block
package ttle_pkg;
  localparam int WORD_W = 40;
  localparam logic [2:0] FMT_REGREG = 3'h6;
  localparam logic [2:0] FMT_SHIMM = 3'h7;
  localparam logic [2:0] FMT_LGIMM = 3'h5;
  localparam logic [6:0] OPC_TRAP = 7'h39;
  localparam logic [6:0] OPC_BR_NEXT_TYPE = 7'h3c;
  localparam logic [6:0] OPC_BR_TAKE_TYPE = 7'h34;
  localparam logic [6:0] OPC_TRAP_TYPE = 7'h38;
  localparam logic [6:0] OPC_LD_LO = 7'h08;
  localparam logic [6:0] OPC_LD_HI = 7'h17;
  localparam logic [6:0] OPC_LD_CAR_CDR = 7'h0c;
  localparam logic [6:0] OPC_LD_CDR = 7'h0d;
  localparam logic [6:0] OPC_LD_HEADER = 7'h0e;
  localparam logic [6:0] OPC_LD_STRUCT = 7'h0f;
  localparam int FMT_HI = 37;
  localparam int FMT_LO = 35;
  localparam int OPC_HI = 34;
  localparam int OPC_LO = 28;
  localparam int S2_HI = 21;
  localparam int S2_LO = 16;
  localparam int COND_HI = 15;
  localparam int COND_LO = 12;
  localparam int C_BIT = 15;
  localparam int H_BIT = 14;
  localparam int TAG_HI = 39;
  localparam int TAG_LO = 38;
  localparam int TYP_HI = 37;
  localparam int TYP_LO = 32;
  localparam logic [5:0] DTP_NIL = 6'h14;
  localparam logic [5:0] DTP_FIXNUM = 6'h08;
  localparam logic [5:0] DTP_LIST = 6'h11;
  localparam logic [5:0] DTP_ARRAY = 6'h1a;
  localparam logic [1:0] CDR_NIL = 2'h1;
  localparam logic [4:0] TRAP_HI_ONES = 5'h1f;
  localparam logic [5:0] ARRAY_HDR_DST = 6'h3e;
  localparam int LONG_PFX_BIT = 24;
  localparam int ALEN_W_DEF = 24;
  localparam logic [7:0] REG_VBASE = 8'h00;
  localparam logic [7:0] REG_WINBASE = 8'h04;
  localparam logic [7:0] REG_TAGS = 8'h08;
  localparam logic [7:0] REG_MADR_ADDR = 8'h0c;
  localparam logic [7:0] REG_MADR_TYPE = 8'h10;
  localparam logic [7:0] REG_ALEN = 8'h14;
  localparam logic [12:0] VBASE_RST = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [39:0] instr;
    logic [39:0] ext;
    logic [39:0] src1;
    logic [39:0] src2;
    logic [31:0] pc;
  } ttle_issue_t;
  typedef enum logic [1:0] {ST_IDLE, ST_MEM1, ST_MEM2} ttle_state_t;
endpackage

/* core/ttle_exec.sv */
// Execution unit for conditional trap, type-test branch/trap and load side effects
`timescale 1ns/10ps
`default_nettype none
module ttle_exec
  import ttle_pkg::*;
#(
  parameter int ALEN_W = ALEN_W_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic issue_valid,
  input wire ttle_issue_t issue,
  output logic issue_ready,
  output logic done,
  output logic [31:0] next_pc,
  output logic redirect,
  output logic trap_taken,
  output logic wb_cancel,
  output logic ret_push,
  output logic [31:0] ret_pc,
  output logic [31:0] window_base_pointer,
  output logic load_trap,
  output logic mem_req_valid,
  output logic [31:0] mem_req_addr,
  input wire logic mem_rsp_valid,
  input wire logic [39:0] mem_rsp_data,
  output logic wb_valid,
  output logic [5:0] wb_dest,
  output logic [39:0] wb_data,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (ALEN_W < 1 || ALEN_W > 32) begin : g_chk
    $error("ALEN_W must lie in 1..32");
  end

  function automatic logic cond_true(input logic [2:0] c, input logic [31:0] a,
                                     input logic [31:0] b);
    case (c)
      3'h0: cond_true = (a == b);
      3'h1: cond_true = (a != b);
      3'h2: cond_true = ($signed(a) < $signed(b));
      3'h3: cond_true = ($signed(a) >= $signed(b));
      3'h4: cond_true = ($signed(a) > $signed(b));
      3'h5: cond_true = ($signed(a) <= $signed(b));
      3'h6: cond_true = 1'b1;
      default: cond_true = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  ttle_state_t state_q;
  logic issue_ready_q, done_q, redirect_q, trap_q, wb_cancel_q, ret_push_q, load_trap_q;
  logic [31:0] next_pc_q, ret_pc_q, winbase_q, mem_addr_q;
  logic mem_req_q, wb_valid_q;
  logic [5:0] wb_dest_q;
  logic [39:0] wb_data_q;
  logic [12:0] vbase_q;
  logic [1:0] list_tag_q;
  logic [5:0] type_cap_q;
  logic [37:0] madr_q;
  logic [ALEN_W-1:0] alen_q;
  logic ld_nil_q, ld_hdr_q;

  // Decode
  logic take;
  logic [2:0] fmt;
  logic [6:0] opc;
  logic regreg, shimm, lgimm;
  logic is_trap, is_bn, is_bt, is_tt, is_load, is_list4;
  logic [5:0] t1;
  logic [39:0] opb;
  logic [3:0] cond;
  logic cmp, tclass_bad, ctrap;
  logic [63:0] onehot;
  logic [31:0] half;
  logic tres, ttrue, ttrap, tbranch, trap_now;
  logic [31:0] seq_pc, trap_pc, br_pc, ld_addr, imm12;
  logic ld_bad, ld_sel_bad;
  logic [5:0] ld_dest;
  assign take = issue_valid & issue_ready_q & clk_en;
  assign fmt = issue.instr[FMT_HI:FMT_LO];
  assign opc = issue.instr[OPC_HI:OPC_LO];
  assign regreg = (fmt == FMT_REGREG);
  assign shimm = (fmt == FMT_SHIMM);
  assign lgimm = (fmt == FMT_LGIMM);
  assign is_trap = (opc == OPC_TRAP);
  assign is_bn = (opc == OPC_BR_NEXT_TYPE);
  assign is_bt = (opc == OPC_BR_TAKE_TYPE);
  assign is_tt = (opc == OPC_TRAP_TYPE);
  assign is_load = (opc >= OPC_LD_LO) && (opc <= OPC_LD_HI);
  assign is_list4 = (opc == OPC_LD_CAR_CDR) || (opc == OPC_LD_CDR) ||
                    (opc == OPC_LD_HEADER) || (opc == OPC_LD_STRUCT);
  assign t1 = issue.src1[TYP_HI:TYP_LO];
  assign cond = issue.instr[COND_HI:COND_LO];
  // Short immediate is a sign-extended fixnum
  assign opb = regreg ? issue.src2 :
               shimm ? {2'h0, DTP_FIXNUM, {26{issue.instr[S2_HI]}}, issue.instr[S2_HI:S2_LO]} :
               issue.ext;
  assign cmp = cond_true(cond[2:0], issue.src1[31:0], opb[31:0]);
  assign tclass_bad = (t1 != opb[TYP_HI:TYP_LO]) || (cond[3] && t1 != DTP_FIXNUM);
  assign ctrap = is_trap & (cmp | tclass_bad);
  assign onehot = 64'h1 << t1;
  assign half = issue.instr[H_BIT] ? onehot[63:32] : onehot[31:0];
  assign tres = |(half & opb[31:0]);
  // Type tests have no short-immediate form; such an encoding never branches
  assign ttrue = (regreg | lgimm) & (issue.instr[C_BIT] ? tres : ~tres);
  assign ttrap = is_tt & ttrue;
  assign tbranch = (is_bn | is_bt) & ttrue;
  assign trap_now = ctrap | ttrap;
  assign seq_pc = issue.pc + (lgimm ? 32'h2 : 32'h1);
  assign trap_pc = {TRAP_HI_ONES, vbase_q, 2'h0, issue.instr[11:0]};
  assign br_pc = {issue.pc[31:12], issue.instr[11:0]};
  assign imm12 = {{20{issue.instr[11]}}, issue.instr[11:0]};
  assign ld_addr = issue.src1[31:0] + (regreg ? issue.src2[31:0] : shimm ? imm12 : issue.ext[31:0]);
  assign ld_dest = shimm ? issue.instr[S2_HI:S2_LO] : issue.instr[5:0];
  always_comb begin
    case (cond)
      4'h1: ld_sel_bad = (t1 != DTP_FIXNUM);
      4'h2: ld_sel_bad = (t1 != DTP_LIST) && (t1 != DTP_NIL);
      4'h3: ld_sel_bad = (t1 != DTP_ARRAY);
      default: ld_sel_bad = 1'b0;
    endcase
  end
  assign ld_bad = ld_sel_bad | (regreg & (issue.src2[TYP_HI:TYP_LO] != DTP_FIXNUM));

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      issue_ready_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          issue_ready_q <= 1'b1;
          if (take && is_load && !ld_bad) begin
            state_q <= ST_MEM1;
            issue_ready_q <= 1'b0;
          end
        end
        ST_MEM1: begin
          if (mem_rsp_valid) begin
            if (ld_hdr_q && mem_rsp_data[LONG_PFX_BIT]) begin
              state_q <= ST_MEM2;
            end else begin
              state_q <= ST_IDLE;
              issue_ready_q <= 1'b1;
            end
          end
        end
        ST_MEM2: begin
          if (mem_rsp_valid) begin
            state_q <= ST_IDLE;
            issue_ready_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic ld_end;
  assign ld_end = mem_rsp_valid && ((state_q == ST_MEM2) ||
                  (state_q == ST_MEM1 && !(ld_hdr_q && mem_rsp_data[LONG_PFX_BIT])));

  // Completion and control transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      redirect_q <= 1'b0;
      trap_q <= 1'b0;
      wb_cancel_q <= 1'b0;
      ret_push_q <= 1'b0;
      load_trap_q <= 1'b0;
      next_pc_q <= 32'h0;
      ret_pc_q <= 32'h0;
    end else if (clk_en) begin
      done_q <= (take && !(is_load && !ld_bad)) || ld_end;
      redirect_q <= take && (trap_now || tbranch);
      trap_q <= take && trap_now;
      wb_cancel_q <= take && trap_now;
      ret_push_q <= take && trap_now;
      load_trap_q <= take && is_load && ld_bad;
      if (take) begin
        next_pc_q <= trap_now ? trap_pc : tbranch ? br_pc : seq_pc;
        ret_pc_q <= seq_pc;
      end
    end
  end

  // Memory request and load side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= 32'h0;
      ld_nil_q <= 1'b0;
      ld_hdr_q <= 1'b0;
      madr_q <= 38'h0;
      wb_dest_q <= 6'h0;
    end else if (clk_en) begin
      if (take && is_load && !ld_bad) begin
        mem_req_q <= 1'b1;
        mem_addr_q <= ld_addr;
        ld_nil_q <= is_list4 && (t1 == DTP_NIL);
        ld_hdr_q <= (ld_dest == ARRAY_HDR_DST);
        wb_dest_q <= ld_dest;
        if (is_list4) begin
          madr_q <= (t1 == DTP_NIL) ? {DTP_NIL, 32'h0} : {t1, ld_addr};
        end
      end else if (state_q == ST_MEM1 && mem_rsp_valid && ld_hdr_q &&
                   mem_rsp_data[LONG_PFX_BIT]) begin
        mem_addr_q <= mem_addr_q + 32'h1;
      end else if (ld_end) begin
        mem_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_valid_q <= 1'b0;
      wb_data_q <= 40'h0;
      list_tag_q <= 2'h0;
      type_cap_q <= 6'h0;
      alen_q <= '0;
    end else if (clk_en) begin
      wb_valid_q <= 1'b0;
      if (state_q == ST_MEM1 && mem_rsp_valid) begin
        wb_valid_q <= 1'b1;
        wb_data_q <= mem_rsp_data;
        list_tag_q <= ld_nil_q ? CDR_NIL : mem_rsp_data[TAG_HI:TAG_LO];
        type_cap_q <= ld_nil_q ? DTP_NIL : mem_rsp_data[TYP_HI:TYP_LO];
        if (ld_hdr_q && !mem_rsp_data[LONG_PFX_BIT]) begin
          alen_q <= mem_rsp_data[ALEN_W-1:0];
        end
      end else if (state_q == ST_MEM2 && mem_rsp_valid) begin
        alen_q <= mem_rsp_data[ALEN_W-1:0];
      end
    end
  end

  // Register slave
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic commit;
  assign commit = aw_hold_q && w_hold_q && !bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (clk_en) begin
      awready_q <= !aw_hold_q && !bvalid_q && !(s_axi_awvalid && awready_q);
      wready_q <= !w_hold_q && !bvalid_q && !(s_axi_wvalid && wready_q);
      if (s_axi_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (commit) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (aw_addr_q == REG_VBASE || aw_addr_q == REG_WINBASE) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  logic [31:0] vbase_word;
  assign vbase_word = merge({19'h0, vbase_q}, w_data_q, w_strb_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbase_q <= VBASE_RST;
      winbase_q <= 32'h0;
    end else if (clk_en) begin
      if (commit && aw_addr_q == REG_VBASE) begin
        vbase_q <= vbase_word[12:0];
      end
      // A trap increment wins over a software write in the same cycle
      if (take && trap_now) begin
        winbase_q <= winbase_q + 32'h1;
      end else if (commit && aw_addr_q == REG_WINBASE) begin
        winbase_q <= merge(winbase_q, w_data_q, w_strb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        case (s_axi_araddr)
          REG_VBASE: rdata_q <= {19'h0, vbase_q};
          REG_WINBASE: rdata_q <= winbase_q;
          REG_TAGS: rdata_q <= {24'h0, list_tag_q, type_cap_q};
          REG_MADR_ADDR: rdata_q <= madr_q[31:0];
          REG_MADR_TYPE: rdata_q <= {26'h0, madr_q[37:32]};
          REG_ALEN: rdata_q <= 32'(alen_q);
          default: begin
            rdata_q <= 32'h0;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign issue_ready = issue_ready_q;
  assign done = done_q;
  assign next_pc = next_pc_q;
  assign redirect = redirect_q;
  assign trap_taken = trap_q;
  assign wb_cancel = wb_cancel_q;
  assign ret_push = ret_push_q;
  assign ret_pc = ret_pc_q;
  assign window_base_pointer = winbase_q;
  assign load_trap = load_trap_q;
  assign mem_req_valid = mem_req_q;
  assign mem_req_addr = mem_addr_q;
  assign wb_valid = wb_valid_q;
  assign wb_dest = wb_dest_q;
  assign wb_data = wb_data_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;

  // Checks
  logic [39:0] rsp_tags;
  assign rsp_tags = {32'h0, mem_rsp_data[TAG_HI:TYP_LO]};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_trap_vector: assert property (take && trap_now |=>
    next_pc_q[31:27] == TRAP_HI_ONES && next_pc_q[13:12] == 2'h0 &&
    next_pc_q[26:14] == $past(vbase_q))
    else $error("trap vector malformed");
  chk_trap_push: assert property (take && trap_now |=>
    ret_push_q && ret_pc_q == $past(seq_pc) && winbase_q == $past(winbase_q) + 32'h1)
    else $error("trap push or window increment wrong");
  chk_seq_pc: assert property (take && !trap_now && !tbranch |=>
    !redirect_q && next_pc_q == $past(issue.pc) + ($past(lgimm) ? 32'h2 : 32'h1))
    else $error("sequential pc wrong");
  chk_ctrap_cancel: assert property (take && ctrap |=> trap_q && wb_cancel_q && redirect_q)
    else $error("conditional trap not taken");
  chk_type_class: assert property (take && is_trap && tclass_bad |=> trap_q)
    else $error("operand type check did not trap");
  chk_type_onehot: assert property (take && is_tt && regreg && issue.instr[C_BIT] &&
    (issue.instr[H_BIT] == t1[5]) && issue.src2[t1[4:0]] |=> trap_q)
    else $error("type test missed set mask bit");
  chk_type_sense: assert property (take && is_bn && lgimm && !issue.instr[C_BIT] &&
    issue.ext[31:0] == 32'h0 |=> redirect_q && next_pc_q == $past(br_pc))
    else $error("clear sense bit did not branch on false");
  chk_load_addr: assert property (take && is_load && !ld_bad |=>
    mem_req_valid && mem_req_addr == $past(ld_addr) && !issue_ready_q)
    else $error("load address wrong");
  chk_load_trap: assert property (take && is_load && ld_bad |=> load_trap_q && !mem_req_q)
    else $error("load source type trap missing");
  chk_load_tags: assert property (state_q == ST_MEM1 && mem_rsp_valid && clk_en &&
    !ld_nil_q |=> {32'h0, list_tag_q, type_cap_q} == $past(rsp_tags))
    else $error("load tags not captured");
  chk_load_nil: assert property (state_q == ST_MEM1 && mem_rsp_valid && clk_en &&
    ld_nil_q |=> list_tag_q == CDR_NIL && type_cap_q == DTP_NIL)
    else $error("empty list tags wrong");
  cov_trap: cover property (take && trap_now ##1 trap_q);
  cov_branch: cover property (take && tbranch);
  cov_long_hdr: cover property (state_q == ST_MEM1 ##[1:20] state_q == ST_MEM2);
  cov_axi_wr: cover property (commit && aw_addr_q == REG_VBASE);
endmodule
`default_nettype wire

/* tb/ttle_mem_model.sv */
// Memory partner that answers reads with tagged words
`timescale 1ns/10ps
`default_nettype none
module ttle_mem_model (
  input wire logic aclk,
  input wire logic mem_req_valid,
  input wire logic [31:0] mem_req_addr,
  output logic mem_rsp_valid,
  output logic [39:0] mem_rsp_data
);
  logic [39:0] mem [16];
  logic [1:0] cnt;
  logic slow;
  initial begin
    mem_rsp_valid = 1'b0;
    mem_rsp_data = 40'h5a5a5a5a5a;
    cnt = 2'h0;
    slow = 1'b0;
  end
  // Data toggles outside a response so a stale word never looks valid
  always @(posedge aclk) begin
    mem_rsp_data <= ~mem_rsp_data;
    if (mem_rsp_valid || !mem_req_valid) begin
      mem_rsp_valid <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == {slow, 1'b0}) begin
      // Alternates prompt and slow answers
      mem_rsp_valid <= 1'b1;
      mem_rsp_data <= mem[mem_req_addr[3:0]];
      slow <= ~slow;
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the type-test, trap and load execution unit
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ttle_pkg::*;
();
  localparam logic [5:0] FX = DTP_FIXNUM;
  localparam logic [5:0] LS = DTP_LIST;
  logic aclk, aresetn, clk_en, issue_valid, issue_ready, done, redirect, trap_taken;
  logic wb_cancel, ret_push, load_trap, mem_req_valid, mem_rsp_valid, wb_valid;
  logic [31:0] next_pc, ret_pc, window_base_pointer, mem_req_addr, s_axi_wdata, s_axi_rdata;
  logic [39:0] mem_rsp_data, wb_data;
  logic [5:0] wb_dest;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, seen_req, seen_wb;
  logic [31:0] req_addr, winbase;
  logic [12:0] vbase;
  ttle_issue_t issue;
  int miscompares, checks_done;

  ttle_exec ttle_exec_i (
    .aclk, .aresetn, .clk_en, .issue_valid, .issue, .issue_ready, .done, .next_pc, .redirect,
    .trap_taken, .wb_cancel, .ret_push, .ret_pc, .window_base_pointer, .load_trap,
    .mem_req_valid, .mem_req_addr, .mem_rsp_valid, .mem_rsp_data, .wb_valid, .wb_dest,
    .wb_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ttle_mem_model ttle_mem_model_i (
    .aclk, .mem_req_valid, .mem_req_addr, .mem_rsp_valid, .mem_rsp_data
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [39:0] w(input logic [5:0] t, input logic [31:0] v);
    return {2'b00, t, v};
  endfunction
  function automatic logic [31:0] seq(input logic [31:0] p, input logic [2:0] f);
    return p + ((f == FMT_LGIMM) ? 32'h2 : 32'h1);
  endfunction

  task automatic test_done();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    test_done();
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, wd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      #1;
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) begin
        chk(40'(s_axi_bresp), 40'(er));
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      #1;
      ar = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        chk(40'(s_axi_rdata), 40'(ed));
        chk(40'(s_axi_rresp), 40'(er));
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    tmo();
  endtask

  // Issues one instruction and returns in the cycle its completion pulses stand
  task automatic run(input logic [39:0] ins, input logic [39:0] ex, input logic [39:0] s1,
                     input logic [39:0] s2, input logic [31:0] pc);
    logic tk;
    tk = 1'b0;
    seen_req = 1'b0;
    seen_wb = 1'b0;
    @(posedge aclk);
    issue <= '{ins, ex, s1, s2, pc};
    issue_valid <= 1'b1;
    for (int n = 0; n < 60 && !tk; n++) begin
      #1;
      tk = issue_ready;
      @(posedge aclk);
    end
    issue_valid <= 1'b0;
    if (!tk) tmo();
    for (int n = 0; n < 60; n++) begin
      #1;
      if (mem_req_valid && !seen_req) begin
        seen_req = 1'b1;
        req_addr = mem_req_addr;
      end
      if (wb_valid) seen_wb = 1'b1;
      if (done || load_trap) return;
      @(posedge aclk);
    end
    tmo();
  endtask
  task automatic chk_flow(input logic tr, input logic rd, input logic [31:0] np);
    chk(40'(done), 40'h1);
    chk(40'(trap_taken), 40'(tr));
    chk(40'(wb_cancel), 40'(tr));
    chk(40'(ret_push), 40'(tr));
    chk(40'(redirect), 40'(rd));
    chk(40'(next_pc), 40'(np));
  endtask

  task automatic sc_cond(input logic [2:0] f, input logic [3:0] cd, input logic [39:0] s1,
                         input logic [39:0] s2, input logic tr);
    logic [31:0] pc;
    pc = 32'h00012345;
    run({2'b00, f, OPC_TRAP, 6'h00, s2[5:0], cd, 12'h123}, s2, s1, s2, pc);
    chk_flow(tr, tr, tr ? {TRAP_HI_ONES, vbase, 2'b00, 12'h123} : seq(pc, f));
    if (tr) chk(40'(ret_pc), 40'(seq(pc, f)));
    winbase = winbase + 32'(tr);
    chk(40'(window_base_pointer), 40'(winbase));
  endtask
  task automatic sc_type(input logic [6:0] op, input logic [2:0] f, input logic h,
                         input logic c, input logic [5:0] t, input logic [31:0] m);
    logic hit, go, tr;
    logic [31:0] pc;
    pc = 32'h00034567;
    hit = (t[5] == h) && m[t[4:0]];
    go = (f != FMT_SHIMM) && (c ? hit : !hit);
    tr = go && (op == OPC_TRAP_TYPE);
    run({2'b00, f, op, 12'h000, c, h, 2'b00, 12'h0ab}, {8'h00, m}, w(t, 0), {8'h00, m}, pc);
    chk_flow(tr, go, tr ? {TRAP_HI_ONES, vbase, 2'b00, 12'h0ab} :
             go ? {pc[31:12], 12'h0ab} : seq(pc, f));
    winbase = winbase + 32'(tr);
    chk(40'(window_base_pointer), 40'(winbase));
  endtask
  task automatic sc_load(input logic [6:0] op, input logic [2:0] f, input logic [3:0] ty,
      input logic [39:0] s1, input logic [39:0] s2, input logic [5:0] d, input logic lt);
    logic rs;
    logic [31:0] a;
    rs = (f == FMT_SHIMM);
    a = s1[31:0] + (rs ? {{20{s2[11]}}, s2[11:0]} : s2[31:0]);
    run({2'b00, f, op, 6'h00, rs ? d : 6'h00, ty, rs ? s2[11:0] : {6'h00, d}}, s2, s1, s2, 0);
    chk(40'(load_trap), 40'(lt));
    chk(40'(seen_req), 40'(!lt));
    if (!lt) begin
      chk(40'(req_addr), 40'(a));
      chk(40'(seen_wb), 40'h1);
      chk(40'(wb_dest), 40'(d));
      chk(wb_data, ttle_mem_model_i.mem[a[3:0]]);
    end
  endtask

  initial begin
    {aresetn, issue_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    clk_en = 1'b1;
    issue = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {miscompares, checks_done, winbase} = '0;
    ttle_mem_model_i.mem[2] = w(FX, 32'h00000222);
    ttle_mem_model_i.mem[3] = {2'h1, 6'h2a, 32'h00000333};
    ttle_mem_model_i.mem[5] = {2'h2, LS, 32'hdeadbeef};
    ttle_mem_model_i.mem[7] = {2'h3, 6'h2a, 32'h00000777};
    ttle_mem_model_i.mem[8] = w(DTP_ARRAY, 32'h00000010);
    ttle_mem_model_i.mem[9] = w(DTP_ARRAY, 32'h01000005);
    ttle_mem_model_i.mem[10] = w(FX, 32'h00abcdef);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_VBASE, 32'h0, RESP_OKAY);
    axi_rd(REG_WINBASE, 32'h0, RESP_OKAY);
    axi_wr(REG_VBASE, 32'h00000abc, RESP_OKAY);
    vbase = 13'h0abc;
    axi_rd(REG_VBASE, 32'h00000abc, RESP_OKAY);
    axi_wr(8'h18, 32'h1, RESP_SLVERR);
    axi_rd(8'h18, 32'h0, RESP_SLVERR);
    sc_cond(FMT_REGREG, 4'h0, w(FX, 5), w(FX, 5), 1'b1);
    sc_cond(FMT_REGREG, 4'h1, w(FX, 5), w(FX, 5), 1'b0);
    sc_cond(FMT_SHIMM, 4'h0, w(FX, 5), w(FX, 5), 1'b1);
    sc_cond(FMT_LGIMM, 4'h7, w(FX, 5), w(FX, 5), 1'b0);
    sc_cond(FMT_LGIMM, 4'h2, w(FX, 32'hffffffff), w(FX, 1), 1'b1);
    sc_cond(FMT_REGREG, 4'h7, w(LS, 5), w(FX, 5), 1'b1);
    sc_cond(FMT_REGREG, 4'h8, w(LS, 5), w(LS, 5), 1'b1);
    sc_cond(FMT_REGREG, 4'hf, w(FX, 1), w(FX, 2), 1'b0);
    sc_type(OPC_BR_NEXT_TYPE, FMT_REGREG, 1'b0, 1'b1, 6'h03, 32'h8);
    sc_type(OPC_BR_NEXT_TYPE, FMT_REGREG, 1'b1, 1'b1, 6'h03, 32'h8);
    sc_type(OPC_BR_NEXT_TYPE, FMT_LGIMM, 1'b0, 1'b0, 6'h03, 32'h0);
    sc_type(OPC_BR_TAKE_TYPE, FMT_LGIMM, 1'b1, 1'b1, 6'h23, 32'h8);
    sc_type(OPC_BR_TAKE_TYPE, FMT_LGIMM, 1'b1, 1'b0, 6'h23, 32'h8);
    sc_type(OPC_TRAP_TYPE, FMT_REGREG, 1'b0, 1'b0, 6'h1f, 32'h7fffffff);
    sc_type(OPC_TRAP_TYPE, FMT_LGIMM, 1'b1, 1'b1, 6'h3f, 32'h80000000);
    sc_type(OPC_BR_NEXT_TYPE, FMT_SHIMM, 1'b0, 1'b1, 6'h03, 32'h8);
    axi_rd(REG_WINBASE, winbase, RESP_OKAY);
    sc_load(OPC_LD_LO, FMT_REGREG, 4'h0, w(FX, 2), w(FX, 3), 6'h05, 1'b0);
    axi_rd(REG_TAGS, 32'h91, RESP_OKAY);
    sc_load(OPC_LD_HI, FMT_SHIMM, 4'h0, w(FX, 4), 40'hfff, 6'h07, 1'b0);
    axi_rd(REG_TAGS, 32'h6a, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      sc_load(OPC_LD_CAR_CDR + 7'(i), FMT_REGREG, 4'h0, w(DTP_NIL, 0), w(FX, 2), 6'h01, 1'b0);
      axi_rd(REG_TAGS, 32'h54, RESP_OKAY);
      axi_rd(REG_MADR_TYPE, 32'h14, RESP_OKAY);
      axi_rd(REG_MADR_ADDR, 32'h0, RESP_OKAY);
    end
    sc_load(7'h10, FMT_REGREG, 4'h0, w(DTP_NIL, 0), w(FX, 5), 6'h02, 1'b0);
    axi_rd(REG_TAGS, 32'h91, RESP_OKAY);
    sc_load(OPC_LD_CDR, FMT_REGREG, 4'h0, w(LS, 6), w(FX, 1), 6'h02, 1'b0);
    axi_rd(REG_MADR_ADDR, 32'h7, RESP_OKAY);
    axi_rd(REG_MADR_TYPE, 32'(LS), RESP_OKAY);
    axi_rd(REG_TAGS, 32'hea, RESP_OKAY);
    sc_load(OPC_LD_LO, FMT_REGREG, 4'h0, w(FX, 8), w(FX, 0), ARRAY_HDR_DST, 1'b0);
    axi_rd(REG_ALEN, 32'h10, RESP_OKAY);
    sc_load(OPC_LD_LO, FMT_REGREG, 4'h0, w(FX, 9), w(FX, 0), ARRAY_HDR_DST, 1'b0);
    axi_rd(REG_ALEN, 32'h00abcdef, RESP_OKAY);
    sc_load(OPC_LD_LO, FMT_REGREG, 4'h1, w(LS, 1), w(FX, 1), 6'h03, 1'b1);
    sc_load(OPC_LD_LO, FMT_REGREG, 4'h0, w(FX, 1), w(LS, 1), 6'h03, 1'b1);
    sc_load(OPC_LD_LO, FMT_SHIMM, 4'h2, w(DTP_NIL, 4), 40'h001, 6'h09, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
